// File: src/nvmwps_consts.svh
// Purpose: Constants of the flash write-protect sequencer
// Assumes: Included by its bare name
// Notes: Offsets are word indices on the register port
`ifndef NVMWPS_CONSTS_SVH
`define NVMWPS_CONSTS_SVH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define NVMWPS_REG_CTRL 4'h0
`define NVMWPS_REG_UNLOCK 4'h1
`define NVMWPS_REG_ADRL 4'h2
`define NVMWPS_REG_ADRH 4'h3
`define NVMWPS_REG_DATL 4'h4
`define NVMWPS_REG_DATH 4'h5
`define NVMWPS_REG_PROT 4'h6
`define NVMWPS_REG_STAT 4'h7
`define NVMWPS_REG_MASK 4'h8
`define NVMWPS_REG_BULK 4'h9

// ---------------------------------------------
// Control bits, unlock keys and status bits
// ---------------------------------------------
`define NVMWPS_CTRL_START 0
`define NVMWPS_CTRL_ERASE 1
`define NVMWPS_CTRL_LATCH 2
`define NVMWPS_CTRL_FAULT 3
`define NVMWPS_CTRL_BUSY 4
`define NVMWPS_KEY1 8'h55
`define NVMWPS_KEY2 8'haa
`define NVMWPS_STAT_DONE 0
`define NVMWPS_STAT_FAULT 1

// ---------------------------------------------
// Protection word layout
// ---------------------------------------------
`define NVMWPS_PROT_RESET 14'h3fff
`define NVMWPS_PROT_ONES 14'h1460
`define NVMWPS_PROT_STICKY 14'h0b80
`define NVMWPS_PROT_SAF 11
`define NVMWPS_PROT_CFG 9
`define NVMWPS_PROT_BOOT 8
`define NVMWPS_PROT_APP 7
`define NVMWPS_PROT_STORAGE_AREA_ENABLE_N_N 4
`define NVMWPS_PROT_BOOT_BLOCK_ENABLE_N_N 3

// ---------------------------------------------
// Array geometry and timing
// ---------------------------------------------
`define NVMWPS_ROW_WORDS 32
`define NVMWPS_LATCH_BLANK 14'h03ff
`define NVMWPS_SAF_BASE 14'h3f80
`define NVMWPS_ERASE_CYCLES 8'd40

`endif

// File: src/nvmwps_pkg.sv
// Purpose: Types of the flash write-protect sequencer
// Assumes: Nothing
// Notes: None
`default_nettype none
package nvmwps_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_BULK} nvmwps_state_t;
  typedef enum logic [1:0] {UL_NONE, UL_KEY1, UL_ARMED} nvmwps_unlock_t;
  typedef struct packed {
    logic wrEn;
    logic eraseEn;
    logic bulkEn;
    logic [14:0] addr;
    logic [13:0] data;
  } nvmwps_flash_t;
endpackage
`default_nettype wire

// File: src/nvmwps_region_check.sv
// Purpose: Decide whether a flash address is write protected
// Assumes: Address bit 14 selects configuration space
// Notes: Purely combinational
`include "nvmwps_consts.svh"
`default_nettype none
module nvmwps_region_check (
  input wire logic [14:0] addr,
  input wire logic [13:0] protWord,
  output logic isProtected
);
  logic safEnabled;
  logic bootEnabled;
  logic [13:0] bootEnd;
  logic inSaf;
  logic inBoot;

  always_comb begin
    safEnabled = ~protWord[`NVMWPS_PROT_STORAGE_AREA_ENABLE_N_N];
    bootEnabled = ~protWord[`NVMWPS_PROT_BOOT_BLOCK_ENABLE_N_N];
    bootEnd = {1'b0, {1'b0, protWord[2:0]} + 4'h1, 9'h000};
    inSaf = safEnabled && (addr[13:0] >= `NVMWPS_SAF_BASE);
    inBoot = bootEnabled && (addr[13:0] < bootEnd);
    if (addr[14]) begin
      isProtected = ~protWord[`NVMWPS_PROT_CFG];
    end else if (inSaf) begin
      isProtected = ~protWord[`NVMWPS_PROT_SAF];
    end else if (inBoot) begin
      isProtected = ~protWord[`NVMWPS_PROT_BOOT];
    end else begin
      isProtected = ~protWord[`NVMWPS_PROT_APP];
    end
  end
endmodule
`default_nettype wire

// File: src/nvmwps_latch_bank.sv
// Purpose: Row of write latches in flip-flops
// Assumes: One load or one clear per cycle
// Notes: Clear returns every latch to the blank value
`include "nvmwps_consts.svh"
`default_nettype none
module nvmwps_latch_bank (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic clearAll,
  input wire logic [4:0] loadIdx,
  input wire logic [13:0] loadData,
  input wire logic [4:0] readIdx,
  output logic [13:0] readData
);
  logic [13:0] latchMem [`NVMWPS_ROW_WORDS];

  genvar i;
  generate
    for (i = 0; i < `NVMWPS_ROW_WORDS; i++) begin : gLatch
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          latchMem[i] <= `NVMWPS_LATCH_BLANK;
        end else if (clearAll) begin
          latchMem[i] <= `NVMWPS_LATCH_BLANK;
        end else if (load && (loadIdx == 5'(i))) begin
          latchMem[i] <= loadData;
        end
      end
    end
  endgenerate

  assign readData = latchMem[readIdx];
endmodule
`default_nettype wire

// File: src/nvmwps_sequencer.sv
// Purpose: Self-programming sequencer with write protection
// Assumes: Register port master never issues read and write together
// Notes: devRstReq is a warm device reset that aborts a running operation
// Overview of operation
// - Erase or row-write start on a protected address sets the fault flag; latch-only start does not.
// - Warm reset during a running write sets the fault flag.
// - Broken unlock sequence sets the fault flag.
// - Software may set the fault flag; only software clears it.
// - Row erase clears all 32 words of the addressed row; data ignored.
// - Protected erase or row write clears start, flags fault, leaves memory.
// - Latch-only mode copies data into the latch at the low address bits.
// - Row write programs latches to flash, then blanks latches to 3FFh.
// - Protection bits only go to protected; bulk erase restores them.
// - Storage area enable bit is active low.
`include "nvmwps_consts.svh"
`default_nettype none
module nvmwps_sequencer (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic devRstReq,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic busy,
  output logic irq,
  output var nvmwps_pkg::nvmwps_flash_t flashPort
);
  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  nvmwps_pkg::nvmwps_state_t state_r;
  nvmwps_pkg::nvmwps_unlock_t unlock_r;
  logic [7:0] nvAddressLow_r;
  logic [6:0] nvAddressHigh_r;
  logic [7:0] nvDataLow_r;
  logic [5:0] nvDataHigh_r;
  logic [13:0] protWord_r;
  logic eraseSelect_r;
  logic latchOnlySelect_r;
  logic startBit_r;
  logic nvmFaultFlag_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [4:0] progIdx_r;
  logic [7:0] waitCnt_r;

  // ---------------------------------------------
  // Decode
  // ---------------------------------------------
  logic [14:0] nvAddr;
  logic [13:0] nvData;
  logic wrCtrl;
  logic wrUnlock;
  logic wrBulk;
  logic startReq;
  logic unlockBreak;
  logic armedGo;
  logic addrProtected;
  logic latchLoad;
  logic opBlocked;
  logic opBegin;
  logic bulkBegin;
  logic progLast;
  logic opDone;
  logic abortOp;
  logic faultSet;
  logic [13:0] latchWord;

  assign nvAddr = {nvAddressHigh_r, nvAddressLow_r};
  assign nvData = {nvDataHigh_r, nvDataLow_r};
  assign wrCtrl = regWrEn && (regAddr == `NVMWPS_REG_CTRL);
  assign wrUnlock = regWrEn && (regAddr == `NVMWPS_REG_UNLOCK);
  assign wrBulk = regWrEn && (regAddr == `NVMWPS_REG_BULK) && regWrData[0];
  assign startReq = wrCtrl && regWrData[`NVMWPS_CTRL_START] && (state_r == nvmwps_pkg::ST_IDLE);
  assign armedGo = unlock_r == nvmwps_pkg::UL_ARMED;

  // A write other than the expected next step breaks the unlock
  always_comb begin
    unlockBreak = 1'b0;
    if (regWrEn) begin
      case (unlock_r)
        nvmwps_pkg::UL_KEY1: begin
          unlockBreak = !(wrUnlock && regWrData[7:0] == `NVMWPS_KEY2);
        end
        nvmwps_pkg::UL_ARMED: begin
          unlockBreak = !(startReq || wrBulk);
        end
        default: begin
          unlockBreak = 1'b0;
        end
      endcase
    end
  end

  nvmwps_region_check uRegion (
    .addr(nvAddr),
    .protWord(protWord_r),
    .isProtected(addrProtected)
  );

  always_comb begin
    latchLoad = 1'b0;
    opBlocked = 1'b0;
    opBegin = 1'b0;
    bulkBegin = wrBulk && armedGo && (state_r == nvmwps_pkg::ST_IDLE);
    if (startReq && armedGo) begin
      if (!regWrData[`NVMWPS_CTRL_ERASE] && regWrData[`NVMWPS_CTRL_LATCH]) begin
        latchLoad = 1'b1;
      end else if (addrProtected) begin
        opBlocked = 1'b1;
      end else begin
        opBegin = 1'b1;
      end
    end
  end

  assign progLast = (state_r == nvmwps_pkg::ST_PROG) && (progIdx_r == 5'h1f);
  assign opDone = progLast || ((state_r == nvmwps_pkg::ST_ERASE || state_r == nvmwps_pkg::ST_BULK)
                  && waitCnt_r == 8'h00);
  assign abortOp = devRstReq && (state_r != nvmwps_pkg::ST_IDLE);
  assign faultSet = opBlocked || unlockBreak || abortOp || (startReq && !armedGo);

  // ---------------------------------------------
  // Unlock tracker
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unlock_r <= nvmwps_pkg::UL_NONE;
    end else if (wrUnlock && regWrData[7:0] == `NVMWPS_KEY1) begin
      unlock_r <= nvmwps_pkg::UL_KEY1;
    end else if (wrUnlock && unlock_r == nvmwps_pkg::UL_KEY1 && regWrData[7:0] == `NVMWPS_KEY2) begin
      unlock_r <= nvmwps_pkg::UL_ARMED;
    end else if (regWrEn) begin
      unlock_r <= nvmwps_pkg::UL_NONE;
    end
  end

  // ---------------------------------------------
  // Address, data and selection registers
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nvAddressLow_r <= 8'h00;
      nvAddressHigh_r <= 7'h00;
      nvDataLow_r <= 8'h00;
      nvDataHigh_r <= 6'h00;
      eraseSelect_r <= 1'b0;
      latchOnlySelect_r <= 1'b0;
      mask_r <= 2'h0;
    end else if (regWrEn && state_r == nvmwps_pkg::ST_IDLE) begin
      case (regAddr)
        `NVMWPS_REG_ADRL: nvAddressLow_r <= regWrData[7:0];
        `NVMWPS_REG_ADRH: nvAddressHigh_r <= regWrData[6:0];
        `NVMWPS_REG_DATL: nvDataLow_r <= regWrData[7:0];
        `NVMWPS_REG_DATH: nvDataHigh_r <= regWrData[5:0];
        `NVMWPS_REG_MASK: mask_r <= regWrData[1:0];
        `NVMWPS_REG_CTRL: begin
          eraseSelect_r <= regWrData[`NVMWPS_CTRL_ERASE];
          latchOnlySelect_r <= regWrData[`NVMWPS_CTRL_LATCH];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------
  // Protection word
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      protWord_r <= `NVMWPS_PROT_RESET;
    end else if (bulkBegin) begin
      protWord_r <= `NVMWPS_PROT_RESET;
    end else if (regWrEn && regAddr == `NVMWPS_REG_PROT) begin
      protWord_r <= (regWrData[13:0] & ~`NVMWPS_PROT_STICKY)
                  | (regWrData[13:0] & protWord_r & `NVMWPS_PROT_STICKY)
                  | `NVMWPS_PROT_ONES;
    end
  end

  // ---------------------------------------------
  // Fault flag and start bit
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nvmFaultFlag_r <= 1'b0;
    end else if (faultSet) begin
      nvmFaultFlag_r <= 1'b1;
    end else if (wrCtrl) begin
      nvmFaultFlag_r <= regWrData[`NVMWPS_CTRL_FAULT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      startBit_r <= 1'b0;
    end else if (opBegin || bulkBegin) begin
      startBit_r <= 1'b1;
    end else if (opDone || abortOp || opBlocked) begin
      startBit_r <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Operation sequencer
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= nvmwps_pkg::ST_IDLE;
      progIdx_r <= 5'h00;
      waitCnt_r <= 8'h00;
    end else if (devRstReq) begin
      state_r <= nvmwps_pkg::ST_IDLE;
      progIdx_r <= 5'h00;
    end else begin
      case (state_r)
        nvmwps_pkg::ST_IDLE: begin
          progIdx_r <= 5'h00;
          waitCnt_r <= `NVMWPS_ERASE_CYCLES;
          if (bulkBegin) begin
            state_r <= nvmwps_pkg::ST_BULK;
          end else if (opBegin && regWrData[`NVMWPS_CTRL_ERASE]) begin
            state_r <= nvmwps_pkg::ST_ERASE;
          end else if (opBegin) begin
            state_r <= nvmwps_pkg::ST_PROG;
          end
        end
        nvmwps_pkg::ST_ERASE, nvmwps_pkg::ST_BULK: begin
          waitCnt_r <= waitCnt_r - 8'h01;
          if (opDone) begin
            state_r <= nvmwps_pkg::ST_IDLE;
          end
        end
        nvmwps_pkg::ST_PROG: begin
          progIdx_r <= progIdx_r + 5'h01;
          if (progLast) begin
            state_r <= nvmwps_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= nvmwps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  nvmwps_latch_bank uLatch (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(latchLoad),
    .clearAll(progLast || abortOp),
    .loadIdx(nvAddressLow_r[4:0]),
    .loadData(nvData),
    .readIdx(progIdx_r),
    .readData(latchWord)
  );

  // ---------------------------------------------
  // Flash array port
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flashPort <= '0;
    end else begin
      flashPort.eraseEn <= (state_r == nvmwps_pkg::ST_ERASE) && (waitCnt_r == `NVMWPS_ERASE_CYCLES)
                           && !devRstReq;
      flashPort.bulkEn <= (state_r == nvmwps_pkg::ST_BULK) && (waitCnt_r == `NVMWPS_ERASE_CYCLES)
                          && !devRstReq;
      flashPort.wrEn <= (state_r == nvmwps_pkg::ST_PROG) && !devRstReq;
      if (state_r == nvmwps_pkg::ST_PROG) begin
        flashPort.addr <= {nvAddr[14:5], progIdx_r};
        flashPort.data <= latchWord;
      end else begin
        flashPort.addr <= {nvAddr[14:5], 5'h00};
        flashPort.data <= `NVMWPS_LATCH_BLANK;
      end
    end
  end

  // ---------------------------------------------
  // Event status, mask and interrupt
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= 2'h0;
    end else begin
      status_r <= (regRdEn && regAddr == `NVMWPS_REG_STAT) ? 2'h0 : status_r;
      if (opDone && !devRstReq) begin
        status_r[`NVMWPS_STAT_DONE] <= 1'b1;
      end
      if (faultSet) begin
        status_r[`NVMWPS_STAT_FAULT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      busy <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
      busy <= (state_r != nvmwps_pkg::ST_IDLE);
    end
  end

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      case (regAddr)
        `NVMWPS_REG_CTRL: regRdData <= {11'h000, state_r != nvmwps_pkg::ST_IDLE, nvmFaultFlag_r,
                                        latchOnlySelect_r, eraseSelect_r, startBit_r};
        `NVMWPS_REG_ADRL: regRdData <= {8'h00, nvAddressLow_r};
        `NVMWPS_REG_ADRH: regRdData <= {9'h000, nvAddressHigh_r};
        `NVMWPS_REG_DATL: regRdData <= {8'h00, nvDataLow_r};
        `NVMWPS_REG_DATH: regRdData <= {10'h000, nvDataHigh_r};
        `NVMWPS_REG_PROT: regRdData <= {2'h0, protWord_r | `NVMWPS_PROT_ONES};
        `NVMWPS_REG_STAT: regRdData <= {14'h0000, status_r};
        `NVMWPS_REG_MASK: regRdData <= {14'h0000, mask_r};
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// File: tb/nvmwps_seq_assertions.sv
// Purpose: Port checker for the flash write-protect sequencer
// Assumes: Bound to nvmwps_sequencer
// Notes: One clock domain
`include "nvmwps_consts.svh"
`default_nettype none
module nvmwps_seq_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic devRstReq,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic busy,
  input wire logic irq,
  input wire nvmwps_pkg::nvmwps_flash_t flashPort
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] wrRun;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------
  // Length of the current program burst
  // ---------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) wrRun <= 7'h0;
    else if (flashPort.wrEn) wrRun <= wrRun + 7'h1;
    else wrRun <= 7'h0;
  end
  sequence latchStart;
    regWrEn && regAddr == `NVMWPS_REG_CTRL && regWrData[2:0] == 3'b101 && !busy;
  endsequence
  sequence statRead;
    !regWrEn ##1 regRdEn && regAddr == `NVMWPS_REG_STAT && !busy && !devRstReq
      ##1 !busy && !regWrEn && !devRstReq;
  endsequence
  chk_row_length: assert property (
    flashPort.wrEn |-> wrRun < 7'd32) else $error("program burst longer than a row");
  chk_row_contig: assert property (
    flashPort.wrEn && $past(flashPort.wrEn) |-> flashPort.addr == $past(flashPort.addr) + 15'h1)
    else $error("program burst address not consecutive");
  chk_erase_base: assert property (
    flashPort.eraseEn |-> flashPort.addr[4:0] == 5'h0) else $error("erase address not a row base");
  chk_erase_pulse: assert property (
    flashPort.eraseEn |=> !flashPort.eraseEn) else $error("erase strobe longer than one cycle");
  chk_one_strobe: assert property (
    $onehot0({flashPort.wrEn, flashPort.eraseEn, flashPort.bulkEn})) else $error("two flash strobes at once");
  chk_latch_quiet: assert property (
    latchStart |=> (!flashPort.wrEn && !flashPort.eraseEn) [*4]) else $error("latch load touched flash");
  chk_abort_stop: assert property (
    devRstReq && busy |-> ##2 !flashPort.wrEn [*3]) else $error("program burst survived warm reset");
  chk_stat_clear: assert property (
    statRead |=> !irq) else $error("interrupt held after status read");
endmodule
`default_nettype wire

// File: tb/nvm_write_protect_sequencer_test.sv
// Purpose: Self-checking bench for the flash write-protect sequencer
// Assumes: Register port with one-cycle strobes
// Notes: Random data from a fixed seed
`include "nvmwps_consts.svh"
`default_nettype none
module nvm_write_protect_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic devRstReq = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic busy;
  logic irq;
  nvmwps_pkg::nvmwps_flash_t flashPort;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int wrCnt = 0;
  int erCnt = 0;
  int buCnt = 0;
  int w0;
  logic [14:0] erAddr;
  logic [13:0] rowData [32];
  logic [15:0] rdVal;
  logic [15:0] pw;
  logic [14:0] adr;
  logic [4:0] idx;
  logic [13:0] dat = 14'h0;
  logic [15:0] protTab [4] = '{16'h37ff, 16'h37ef, 16'h3ef0, 16'h3ef0};
  logic [14:0] adrTab [4] = '{15'h3f90, 15'h3f90, 15'h0100, 15'h0300};
  bit okTab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  always #50 core_clk = ~core_clk;

  nvmwps_sequencer dut_u (.core_clk(core_clk), .nrst(nrst), .devRstReq(devRstReq), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .busy(busy),
    .irq(irq), .flashPort(flashPort));

  // ---------------------------------------------
  // Flash strobe monitor and watchdog
  // ---------------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (flashPort.wrEn) begin
      wrCnt <= wrCnt + 1;
      rowData[flashPort.addr[4:0]] <= flashPort.data;
    end
    if (flashPort.eraseEn) begin
      erCnt <= erCnt + 1;
      erAddr <= flashPort.addr;
    end
    if (flashPort.bulkEn) buCnt <= buCnt + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(negedge core_clk);
    rdVal = regRdData;
  endtask

  task automatic unlock();
    wr(`NVMWPS_REG_UNLOCK, 16'h0055);
    wr(`NVMWPS_REG_UNLOCK, 16'h00aa);
  endtask

  task automatic waitIdle();
    int n = 0;
    repeat (3) @(negedge core_clk);
    while (busy !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk("busy", 16'h0, {15'h0, busy});
  endtask

  // Sets address and data, optionally unlocks, starts and checks the outcome
  task automatic op(input logic [2:0] ctl, input logic [14:0] a, input bit ok, input bit unl);
    int e0;
    w0 = wrCnt;
    e0 = erCnt;
    wr(`NVMWPS_REG_ADRL, {8'h0, a[7:0]});
    wr(`NVMWPS_REG_ADRH, {9'h0, a[14:8]});
    wr(`NVMWPS_REG_DATL, {8'h0, dat[7:0]});
    wr(`NVMWPS_REG_DATH, {10'h0, dat[13:8]});
    if (unl) unlock();
    wr(`NVMWPS_REG_CTRL, {13'h0, ctl});
    waitIdle();
    rd(`NVMWPS_REG_CTRL);
    chk("faultFlag", {15'h0, !ok}, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    chk("startBit", 16'h0, {15'h0, rdVal[`NVMWPS_CTRL_START]});
    chk("rowWrites", (ctl == 3'h1 && ok) ? 16'd32 : 16'd0, 16'(wrCnt - w0));
    chk("erases", (ctl == 3'h3 && ok) ? 16'd1 : 16'd0, 16'(erCnt - e0));
  endtask

  // Protection word after a write: sticky bits only clear, unused bits read one
  function automatic logic [15:0] protNext(input logic [15:0] old, input logic [15:0] d);
    return {2'h0, (d[13:0] & ~`NVMWPS_PROT_STICKY) | (d[13:0] & old[13:0] & `NVMWPS_PROT_STICKY)
            | `NVMWPS_PROT_ONES};
  endfunction

  task automatic bulk();
    int b0;
    b0 = buCnt;
    unlock();
    wr(`NVMWPS_REG_BULK, 16'h0001);
    waitIdle();
    chk("bulkErase", 16'h1, 16'(buCnt - b0));
    rd(`NVMWPS_REG_PROT);
    chk("protAfterBulk", 16'h3fff, rdVal);
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(16));
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rd(`NVMWPS_REG_PROT);
    chk("protReset", 16'h3fff, rdVal);
    wr(`NVMWPS_REG_MASK, 16'h0001);
    idx = 5'($urandom());
    dat = 14'($urandom());
    op(3'h5, {10'h008, idx}, 1'b1, 1'b1);
    op(3'h1, 15'h0100, 1'b1, 1'b1);
    chk("loadedWord", {2'h0, dat}, {2'h0, rowData[idx]});
    chk("blankWord", 16'h03ff, {2'h0, rowData[idx + 5'h1]});
    chk("irqDone", 16'h1, {15'h0, irq});
    rd(`NVMWPS_REG_STAT);
    chk("statDone", 16'h0001, rdVal);
    repeat (2) @(negedge core_clk);
    chk("irqCleared", 16'h0, {15'h0, irq});
    wr(`NVMWPS_REG_MASK, 16'h0000);
    op(3'h1, 15'h0100, 1'b1, 1'b1);
    chk("latchBlanked", 16'h03ff, {2'h0, rowData[idx]});
    chk("irqMasked", 16'h0, {15'h0, irq});
    wr(`NVMWPS_REG_MASK, 16'h0001);
    repeat (2) @(negedge core_clk);
    chk("irqUnmasked", 16'h1, {15'h0, irq});
    rd(`NVMWPS_REG_STAT);
    wr(`NVMWPS_REG_MASK, 16'h0000);
    adr = {1'b0, 14'($urandom()) % 14'h3f80};
    dat = 14'($urandom());
    op(3'h3, adr, 1'b1, 1'b1);
    chk("eraseRow", {1'b0, adr & 15'h7fe0}, {1'b0, erAddr});
    wr(`NVMWPS_REG_UNLOCK, 16'h0055);
    wr(`NVMWPS_REG_ADRL, 16'h0000);
    rd(`NVMWPS_REG_CTRL);
    chk("brokenUnlock", 16'h1, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    rd(`NVMWPS_REG_STAT);
    chk("statFault", 16'h0003, rdVal);
    op(3'h3, adr, 1'b0, 1'b0);
    rd(`NVMWPS_REG_ADRL);
    chk("adrLow", {8'h0, adr[7:0]}, rdVal);
    rd(`NVMWPS_REG_DATH);
    chk("datHigh", {10'h0, dat[13:8]}, rdVal);
    wr(`NVMWPS_REG_CTRL, 16'h0000);
    rd(`NVMWPS_REG_CTRL);
    chk("faultClear", 16'h0, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    wr(`NVMWPS_REG_CTRL, 16'h0008);
    rd(`NVMWPS_REG_CTRL);
    chk("faultSet", 16'h1, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    wr(`NVMWPS_REG_PROT, 16'h2b1f);
    rd(`NVMWPS_REG_PROT);
    chk("protWord", 16'h3f7f, rdVal);
    wr(`NVMWPS_REG_PROT, 16'h3fff);
    rd(`NVMWPS_REG_PROT);
    chk("protSticky", 16'h3f7f, rdVal);
    rd(`NVMWPS_REG_CTRL);
    chk("faultHeld", 16'h1, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    op(3'h3, 15'h0100, 1'b0, 1'b1);
    op(3'h1, 15'h0100, 1'b0, 1'b1);
    op(3'h5, 15'h0100, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) bulk();
      pw = protNext((i % 2 == 0) ? 16'h3fff : pw, protTab[i]);
      wr(`NVMWPS_REG_PROT, protTab[i]);
      rd(`NVMWPS_REG_PROT);
      chk("protTab", pw, rdVal);
      op(3'h3, adrTab[i], okTab[i], 1'b1);
    end
    w0 = wrCnt;
    unlock();
    wr(`NVMWPS_REG_CTRL, 16'h0001);
    repeat (10) @(posedge core_clk);
    devRstReq <= 1'b1;
    @(posedge core_clk);
    devRstReq <= 1'b0;
    waitIdle();
    rd(`NVMWPS_REG_CTRL);
    chk("abortFault", 16'h1, {15'h0, rdVal[`NVMWPS_CTRL_FAULT]});
    chk("abortShort", 16'h1, {15'h0, wrCnt - w0 < 32});
    test_done();
  end
endmodule

bind nvmwps_sequencer nvmwps_seq_assertions chk_u (.core_clk(core_clk), .nrst(nrst), .devRstReq(devRstReq),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .busy(busy), .irq(irq),
  .flashPort(flashPort));
`default_nettype wire
